// File: hdl/fcc_ctrl.sv
/*
 * Flash command controller: Wishbone classic slave holding software
 * orders, sequencing flash command writes and reads over the pins.
 * Assumes the flash device obeys its command set; pins are asynchronous.
 */
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "fcc_regs.svh"
module fcc_ctrl #(
  parameter int STROBE_CYC = `FCC_T_STROBE_CYC,
  parameter int GAP_CYC = `FCC_T_GAP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flash pins
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic [23:0] flash_addr_o,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe_n_o,
  input wire logic [7:0] flash_dq_i,
  input wire logic ready_busy_out_i,
  // Levels toward the device supplies
  output logic reset_override_pin_n_o,
  output logic override_high_voltage_o
);
  if (STROBE_CYC < 1 || GAP_CYC < 1) begin : g_bad_timing
    $error("fcc_ctrl timing out of range");
  end

  typedef enum logic [2:0] {
    FCC_Q_IDLE = 3'b000,
    FCC_Q_FIRST = 3'b001,
    FCC_Q_W1 = 3'b011,
    FCC_Q_SECOND = 3'b010,
    FCC_Q_W2 = 3'b110
  } fcc_qstate_t;

  // Pin input synchronisers
  logic [7:0] dq_s1_r, dq_s2_r;
  logic rb_s1_r, rb_s2_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end else begin
      dq_s1_r <= flash_dq_i;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= ready_busy_out_i;
      rb_s2_r <= rb_s1_r;
    end
  end

  // Registers and sequencer state
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  fcc_qstate_t q_r, q_nxt;
  logic start_r, start_nxt;
  fcc_pkg::fcc_req_t req_r, req_nxt;
  logic done;
  logic [7:0] rdata;
  fcc_pkg::fcc_pins_t pins;

  function automatic fcc_pkg::fcc_op_t op_of(input logic [31:0] c);
    op_of = fcc_pkg::fcc_op_t'(c[`FCC_CTRL_OP_MSB:`FCC_CTRL_OP_LSB]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  function automatic fcc_pkg::fcc_req_t mk(input fcc_pkg::fcc_cyc_t k, input logic [23:0] a,
                                          input logic [7:0] d);
    mk.kind = k;
    mk.addr = a;
    mk.data = d;
  endfunction

  logic busy;
  logic wb_req;
  logic [31:0] ctrl_w;
  fcc_pkg::fcc_op_t op;
  assign busy = (q_r != FCC_Q_IDLE);
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign op = op_of(ctrl_r);

  always_comb begin
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    rd_nxt = rd_r;
    ack_nxt = 1'b0;
    dat_nxt = dat_r;
    q_nxt = q_r;
    start_nxt = 1'b0;
    req_nxt = req_r;
    ctrl_w = merge(ctrl_r, wb_dat_i, wb_sel_i);
    // Register bus: one-cycle ack, writes ignored while an order runs
    if (wb_req) begin
      ack_nxt = 1'b1;
      unique case (wb_adr_i)
        `FCC_REG_CTRL: dat_nxt = ctrl_r;
        `FCC_REG_ADDR: dat_nxt = {8'h00, addr_r};
        `FCC_REG_DATA: dat_nxt = {24'h000000, data_r};
        `FCC_REG_STAT: dat_nxt = {16'h0000, rd_r, 6'h00, rb_s2_r, busy};
        default: dat_nxt = 32'h0000_0000;
      endcase
      if (wb_we_i && !busy) begin
        unique case (wb_adr_i)
          `FCC_REG_CTRL: ctrl_nxt = ctrl_w;
          `FCC_REG_ADDR: addr_nxt = 24'(merge({8'h00, addr_r}, wb_dat_i, wb_sel_i));
          `FCC_REG_DATA: data_nxt = 8'(merge({24'h000000, data_r}, wb_dat_i, wb_sel_i));
          default: ;
        endcase
      end
    end
    unique case (q_r)
      FCC_Q_IDLE: begin
        if (ctrl_r[`FCC_CTRL_GO]) begin
          ctrl_nxt[`FCC_CTRL_GO] = 1'b0;
          q_nxt = FCC_Q_FIRST;
        end
      end
      FCC_Q_FIRST: begin
        start_nxt = 1'b1;
        q_nxt = FCC_Q_W1;
        unique case (op)
          fcc_pkg::FCC_OP_CMD: req_nxt = mk(fcc_pkg::FCC_CYC_WR, addr_r,
                                            ctrl_r[`FCC_CTRL_DATA_MSB:`FCC_CTRL_DATA_LSB]);
          fcc_pkg::FCC_OP_WRITE: req_nxt = mk(fcc_pkg::FCC_CYC_WR, addr_r, data_r);
          fcc_pkg::FCC_OP_READ: req_nxt = mk(fcc_pkg::FCC_CYC_RD, addr_r, 8'h00);
          fcc_pkg::FCC_OP_ERASE: req_nxt = mk(fcc_pkg::FCC_CYC_WR, addr_r, `FCC_CMD_ERASE);
          fcc_pkg::FCC_OP_PROG: req_nxt = mk(fcc_pkg::FCC_CYC_WR, addr_r, `FCC_CMD_PROG);
          fcc_pkg::FCC_OP_IDENT: req_nxt = mk(fcc_pkg::FCC_CYC_WR, addr_r, `FCC_CMD_IDENT);
          fcc_pkg::FCC_OP_STATUS: req_nxt = mk(fcc_pkg::FCC_CYC_WR, addr_r, `FCC_CMD_STATUS);
          default: req_nxt = mk(fcc_pkg::FCC_CYC_WR, addr_r, `FCC_CMD_STATUS);
        endcase
      end
      FCC_Q_W1: begin
        if (done) begin
          if (op == fcc_pkg::FCC_OP_READ) begin
            rd_nxt = rdata;
          end
          unique case (op)
            fcc_pkg::FCC_OP_ERASE, fcc_pkg::FCC_OP_PROG,
            fcc_pkg::FCC_OP_IDENT, fcc_pkg::FCC_OP_STATUS: q_nxt = FCC_Q_SECOND;
            default: q_nxt = FCC_Q_IDLE;
          endcase
        end
      end
      FCC_Q_SECOND: begin
        start_nxt = 1'b1;
        q_nxt = FCC_Q_W2;
        unique case (op)
          fcc_pkg::FCC_OP_ERASE: req_nxt = mk(fcc_pkg::FCC_CYC_WR, addr_r, `FCC_CMD_CONFIRM);
          fcc_pkg::FCC_OP_PROG: req_nxt = mk(fcc_pkg::FCC_CYC_WR, addr_r, data_r);
          default: req_nxt = mk(fcc_pkg::FCC_CYC_RD, addr_r, 8'h00);
        endcase
      end
      FCC_Q_W2: begin
        if (done) begin
          // Identifier or status byte; status refreshed by a fresh strobe
          if (op == fcc_pkg::FCC_OP_IDENT || op == fcc_pkg::FCC_OP_STATUS) begin
            rd_nxt = rdata;
          end
          q_nxt = FCC_Q_IDLE;
        end
      end
      default: q_nxt = FCC_Q_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `FCC_RST_CTRL;
      addr_r <= 24'h000000;
      data_r <= 8'h00;
      rd_r <= 8'h00;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      q_r <= FCC_Q_IDLE;
      start_r <= 1'b0;
      req_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      rd_r <= rd_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      q_r <= q_nxt;
      start_r <= start_nxt;
      req_r <= req_nxt;
    end
  end

  fcc_cycle #(
    .STROBE_CYC(STROBE_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_r),
    .req_i(req_r),
    .done_o(done),
    .rdata_o(rdata),
    .dq_sync_i(dq_s2_r),
    .pins_o(pins)
  );

  // Override level: reset pin held high, no high voltage from this host
  logic rp_r;
  logic hv_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rp_r <= 1'b0;
      hv_r <= 1'b0;
    end else begin
      rp_r <= 1'b1;
      hv_r <= 1'b0;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign flash_ce_n_o = pins.ce_n;
  assign flash_oe_n_o = pins.oe_n;
  assign flash_we_n_o = pins.we_n;
  assign flash_addr_o = pins.addr;
  assign flash_dq_o = pins.dq_o;
  assign flash_dq_oe_n_o = pins.dq_oe_n;
  assign reset_override_pin_n_o = rp_r;
  assign override_high_voltage_o = hv_r;

  // Erase setup is always followed by the confirm on the same address
  sequence erase_setup_s;
    q_r == FCC_Q_FIRST && op == fcc_pkg::FCC_OP_ERASE;
  endsequence
  erase_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
    erase_setup_s |=> req_r.data == `FCC_CMD_ERASE ##[1:600] (start_r && req_r.data == `FCC_CMD_CONFIRM))
    else $error("erase confirm missing");
  prog_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_r == FCC_Q_SECOND && op == fcc_pkg::FCC_OP_PROG) |=> (req_r.data == data_r && req_r.addr == addr_r))
    else $error("program data write wrong");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  write_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !flash_we_n_o |-> (!flash_dq_oe_n_o && flash_oe_n_o))
    else $error("write strobe without data");
  status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_r == FCC_Q_SECOND && op == fcc_pkg::FCC_OP_STATUS) |=> req_r.kind == fcc_pkg::FCC_CYC_RD)
    else $error("status read missing");

  // Sequencer and register guards
  go_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_r == FCC_Q_IDLE && ctrl_r[`FCC_CTRL_GO]) |=> (q_r == FCC_Q_FIRST && !ctrl_r[`FCC_CTRL_GO]))
    else $error("order not started");
  busy_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_req && wb_we_i && busy) |=> ($stable(addr_r) && $stable(data_r)))
    else $error("register write taken while busy");
  erase_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_r && op == fcc_pkg::FCC_OP_ERASE) |-> req_r.addr == addr_r)
    else $error("erase write off target block");
  prog_setup_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_r == FCC_Q_FIRST && op == fcc_pkg::FCC_OP_PROG) |=> (req_r.data == `FCC_CMD_PROG && req_r.addr == addr_r))
    else $error("program setup wrong");
  ident_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_r == FCC_Q_FIRST && op == fcc_pkg::FCC_OP_IDENT) |=> req_r.data == `FCC_CMD_IDENT)
    else $error("identifier code wrong");
  read_kind_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_r == FCC_Q_FIRST && op == fcc_pkg::FCC_OP_READ) |=> req_r.kind == fcc_pkg::FCC_CYC_RD)
    else $error("read order not a read cycle");
  cycle_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_r |-> ##[1:520] done)
    else $error("pin cycle never finished");
  rp_steady_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reset_override_pin_n_o |=> (reset_override_pin_n_o && !override_high_voltage_o))
    else $error("override level changed");
  ack_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rd_update_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(rd_r) |-> $past(done))
    else $error("read byte changed outside a cycle");
endmodule // fcc_ctrl

// File: hdl/fcc_regs.svh
/*
 * Constants of the flash command controller: command codes, status bit
 * positions, register offsets, bus timing counts and reset values.
 * Assumes inclusion by bare name from the package and the modules.
 */
// Functional notes
// - Identifier mode lasts until the next valid command, at any voltage.
// - Status latched on falling strobe; a strobe must rise again to refresh.
// - Erase is setup 20H then confirm D0H, both at the target block.
// - Program is setup 40H or 10H then a write of address and data.
// - Erase resumes only after suspend-time program ends; levels held steady.
// - Codes: identifier 90H, status 70H, confirm/resume D0H, erase 20H, clear 50H.
`ifndef FCC_REGS_SVH
`define FCC_REGS_SVH

// Device command codes
`define FCC_CMD_ARRAY 8'hFF
`define FCC_CMD_IDENT 8'h90
`define FCC_CMD_STATUS 8'h70
`define FCC_CMD_CLEAR 8'h50
`define FCC_CMD_ERASE 8'h20
`define FCC_CMD_PROG 8'h40
`define FCC_CMD_PROG_ALT 8'h10
`define FCC_CMD_SUSPEND 8'hB0
`define FCC_CMD_CONFIRM 8'hD0

// Device status bits
`define FCC_SR_READY 7
`define FCC_SR_ESUSP 6
`define FCC_SR_EERR 5
`define FCC_SR_PERR 4
`define FCC_SR_LOWV 3
`define FCC_SR_PSUSP 2
`define FCC_SR_LOCK 1

// Device identifier offsets
`define FCC_ID_MAKER 24'h000000
`define FCC_ID_PART 24'h000001
`define FCC_ID_BLOCK_LOCK 16'h0002
`define FCC_ID_GLOBAL_LOCK 24'h000003

// Controller registers, byte addresses
`define FCC_REG_CTRL 4'h0
`define FCC_REG_ADDR 4'h4
`define FCC_REG_DATA 4'h8
`define FCC_REG_STAT 4'hC
// CTRL fields
`define FCC_CTRL_GO 0
`define FCC_CTRL_OP_LSB 1
`define FCC_CTRL_OP_MSB 3
`define FCC_CTRL_DATA_LSB 8
`define FCC_CTRL_DATA_MSB 15
// STAT fields
`define FCC_STAT_BUSY 0
`define FCC_STAT_RDYPIN 1
`define FCC_STAT_RD_LSB 8
`define FCC_STAT_RD_MSB 15

// Pin timing, ns and derived cycles at 25 ns
`define FCC_CLK_NS 25
`define FCC_T_STROBE_NS 100
`define FCC_T_STROBE_CYC ((`FCC_T_STROBE_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)
`define FCC_T_GAP_NS 50
`define FCC_T_GAP_CYC ((`FCC_T_GAP_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)

`define FCC_RST_CTRL 32'h0000_0000

`endif

// File: hdl/fcc_pkg.sv
/*
 * Types of the flash command controller.
 * Assumes fcc_regs.svh is on the include path.
 */
`include "fcc_regs.svh"
package fcc_pkg;
  // Host operations that software orders
  typedef enum logic [2:0] {
    FCC_OP_CMD = 3'h0,    // One command write, data from CTRL
    FCC_OP_WRITE = 3'h1,  // Raw write of ADDR and DATA
    FCC_OP_READ = 3'h2,   // One read at ADDR
    FCC_OP_ERASE = 3'h3,  // Setup plus confirm at ADDR
    FCC_OP_PROG = 3'h4,   // Setup plus data write at ADDR
    FCC_OP_IDENT = 3'h5,  // Identifier command then read at ADDR
    FCC_OP_STATUS = 3'h6  // Status command then read
  } fcc_op_t;

  // Pin cycle kinds
  typedef enum logic [1:0] {
    FCC_CYC_IDLE = 2'h0,
    FCC_CYC_WR = 2'h1,
    FCC_CYC_RD = 2'h3
  } fcc_cyc_t;

  // Flash bus pins
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [23:0] addr;
    logic [7:0] dq_o;
    logic dq_oe_n;
  } fcc_pins_t;

  // One pin request toward the cycle engine
  typedef struct packed {
    fcc_cyc_t kind;
    logic [23:0] addr;
    logic [7:0] data;
  } fcc_req_t;
endpackage

// File: hdl/fcc_cycle.sv
/*
 * Pin cycle engine: runs one write or read strobe on the flash bus.
 * Assumes a synchronised data input and a single-request handshake.
 */
`timescale 1ns/10ps
`include "fcc_regs.svh"
module fcc_cycle #(
  parameter int STROBE_CYC = `FCC_T_STROBE_CYC,
  parameter int GAP_CYC = `FCC_T_GAP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request
  input wire logic start_i,
  input wire fcc_pkg::fcc_req_t req_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  // Pins
  input wire logic [7:0] dq_sync_i,
  output fcc_pkg::fcc_pins_t pins_o
);
  if (STROBE_CYC < 1 || STROBE_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 255) begin : g_bad_timing
    $error("fcc_cycle timing out of range");
  end

  typedef enum logic [1:0] {
    FCC_S_IDLE = 2'b00,
    FCC_S_STROBE = 2'b01,
    FCC_S_GAP = 2'b11
  } fcc_cstate_t;

  fcc_cstate_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  fcc_pkg::fcc_pins_t pins_r, pins_nxt;
  logic done_r, done_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic is_rd_r, is_rd_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pins_nxt = pins_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    is_rd_nxt = is_rd_r;
    unique case (state_r)
      FCC_S_IDLE: begin
        if (start_i) begin
          is_rd_nxt = (req_i.kind == fcc_pkg::FCC_CYC_RD);
          pins_nxt.addr = req_i.addr;
          pins_nxt.dq_o = req_i.data;
          pins_nxt.ce_n = 1'b0;
          pins_nxt.oe_n = ~is_rd_nxt;
          pins_nxt.we_n = is_rd_nxt;
          pins_nxt.dq_oe_n = is_rd_nxt;
          cnt_nxt = 8'(STROBE_CYC);
          state_nxt = FCC_S_STROBE;
        end
      end
      FCC_S_STROBE: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          // Rising strobe latches command, address and data
          if (is_rd_r) begin
            rdata_nxt = dq_sync_i;
          end
          pins_nxt.ce_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          pins_nxt.we_n = 1'b1;
          cnt_nxt = 8'(GAP_CYC);
          state_nxt = FCC_S_GAP;
        end
      end
      FCC_S_GAP: begin
        // Strobes stay high so the status latch can refresh; below
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          pins_nxt.dq_oe_n = 1'b1;
          done_nxt = 1'b1;
          state_nxt = FCC_S_IDLE;
        end
      end
      default: state_nxt = FCC_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= FCC_S_IDLE;
      cnt_r <= 8'h00;
      pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 24'h000000, dq_o: 8'h00, dq_oe_n: 1'b1};
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      is_rd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      is_rd_r <= is_rd_nxt;
    end
  end

  assign done_o = done_r;
  assign rdata_o = rdata_r;
  assign pins_o = pins_r;

  // Each read strobe is followed by both strobes high before the next cycle
  strobe_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pins_r.oe_n) |-> pins_r.ce_n ##1 pins_r.oe_n)
    else $error("read strobe not released");
  data_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pins_r.oe_n |-> pins_r.dq_oe_n)
    else $error("data driven during read");
endmodule // fcc_cycle

// File: test/fcc_flash_model.sv
/*
 * Behavioural byte-wide flash: command decoder, status register, erase and
 * program with suspend and resume, identifier reads. Block 1 is locked.
 * Assumes active-low strobes from the controller; internal tick of 10 ns.
 */
`timescale 1ns/10ps
module fcc_flash_model #(
  parameter logic [7:0] MAKER = 8'h5C, // Arbitrary value
  parameter logic [7:0] PART = 8'h3E, // Arbitrary value
  parameter int ERASE_T = 600,
  parameter int PROG_T = 200
) (
  // Strobes, address, data
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [23:0] addr_i,
  input wire logic [7:0] dq_i,
  // Levels
  input wire logic rp_n_i,
  input wire logic hv_i,
  input wire logic vpp_ok_i,
  // Outputs
  output logic [7:0] dq_o,
  output logic ready_busy_out_o
);
  logic [7:0] mem [4][16];
  logic [7:0] lat, pd;
  logic [5:1] err;
  logic [23:0] pa, ea;
  logic [1:0] mode, pend;
  logic esusp, psusp;
  int erem, prem;
  wire rd_n = ce_n_i | oe_n_i;
  wire wr_n = ce_n_i | we_n_i;
  wire busy_p = prem != 0 && !psusp;
  wire busy_e = erem != 0 && !esusp;
  wire [7:0] sr = {!(busy_p || busy_e), esusp, err[5:3], psusp, err[1], 1'b0};

  assign ready_busy_out_o = !rp_n_i || !(busy_p || busy_e);
  // Released bus shows the inverse of the last value
  assign dq_o = rd_n ? ~lat : lat;

  initial begin
    foreach (mem[b, i]) mem[b][i] = 8'hFF;
    {lat, pd, err, pa, ea, mode, pend, esusp, psusp} = '0;
    erem = 0;
    prem = 0;
  end

  always @(posedge rp_n_i) begin
    mode = 2'd0;
    pend = 2'd0;
  end

  task automatic start(input logic erase, input logic [23:0] a, input logic [7:0] d);
    if (!vpp_ok_i) err = err | 5'b10100;
    else if (a[17:16] == 2'd1 && !hv_i) err = err | (erase ? 5'b10001 : 5'b01001);
    else if (erase) begin
      erem = ERASE_T;
      ea = a;
    end else begin
      prem = PROG_T;
      pa = a;
      pd = d;
    end
  endtask

  always @(posedge wr_n) begin
    if (pend != 2'd0) begin
      mode = 2'd2;
      if (pend == 2'd2) start(1'b0, addr_i, dq_i);
      else if (dq_i == 8'hD0) start(1'b1, addr_i, dq_i);
      else err = err | 5'b11000;
      pend = 2'd0;
    end else if (busy_p || busy_e) begin
      if (dq_i == 8'hB0) begin
        mode = 2'd2;
        if (busy_p) psusp = 1'b1;
        else esusp = 1'b1;
      end
    end else case (dq_i)
      8'hFF: mode = 2'd0;
      8'h90: if (!esusp && !psusp) mode = 2'd1;
      8'h70: mode = 2'd2;
      8'h50: if (!esusp && !psusp) err = 5'b00000;
      8'h20: if (!esusp && !psusp) pend = 2'd1;
      8'h40, 8'h10: if (!psusp) pend = 2'd2;
      8'hD0: begin
        mode = 2'd2;
        if (psusp) psusp = 1'b0;
        else esusp = 1'b0;
      end
      default: ;
    endcase
  end

  // Program takes precedence, so erase waits for it
  always #10 begin
    if (busy_p) begin
      prem = prem - 1;
      if (prem == 0) mem[pa[17:16]][pa[3:0]] = mem[pa[17:16]][pa[3:0]] & pd;
    end else if (busy_e) begin
      erem = erem - 1;
      if (erem == 0) begin
        for (int i = 0; i < 16; i++) mem[ea[17:16]][i] = 8'hFF;
      end
    end
  end

  always @(negedge rd_n) begin
    #1; // Address settles with the strobe
    if (mode == 2'd2) lat = sr;
    else if (mode == 2'd0) lat = mem[addr_i[17:16]][addr_i[3:0]];
    else if (addr_i[1:0] == 2'd0) lat = MAKER;
    else if (addr_i[1:0] == 2'd1) lat = PART;
    else if (addr_i[1:0] == 2'd2) lat = {7'h00, addr_i[17:16] == 2'd1};
    else lat = 8'h00;
  end
endmodule // fcc_flash_model

// File: test/flash_command_state_machine_tb.sv
/*
 * Self-checking bench: Wishbone orders to the controller, flash model behind.
 * Assumes fcc_regs.svh on the include path.
 */
`timescale 1ns/10ps
`include "fcc_regs.svh"
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("mismatch %0t got %h expected %h", $time, g, e); \
    end \
  end
module flash_command_state_machine_tb;
  localparam logic [7:0] MAKER = 8'h5C; // Arbitrary value
  localparam logic [7:0] PART = 8'h3E; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, vpp_ok = 1'b1, got = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, ce_n, oe_n, we_n, dq_oe_n, rp_n, hv, rdy;
  logic [23:0] fa;
  logic [7:0] fdo, fdm, res, b, ex, rd1, rd2;
  logic [7:0] exq[$];
  int miscompares = 0, samples_checked = 0, seed = 49;
  wire [7:0] dq_w = !dq_oe_n ? fdo : fdm;

  always #12.5 clk_i = ~clk_i;

  fcc_ctrl i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_addr_o(fa), .flash_dq_o(fdo),
    .flash_dq_oe_n_o(dq_oe_n), .flash_dq_i(dq_w), .ready_busy_out_i(rdy),
    .reset_override_pin_n_o(rp_n), .override_high_voltage_o(hv));
  fcc_flash_model #(.MAKER(MAKER), .PART(PART)) i_flash (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa), .dq_i(dq_w), .rp_n_i(rp_n), .hv_i(hv),
    .vpp_ok_i(vpp_ok), .dq_o(fdm), .ready_busy_out_o(rdy));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic give_up();
    miscompares++;
    $display("mismatch %0t wait limit reached", $time);
    give_verdict();
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    if (n >= 64) give_up();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic run(input fcc_pkg::fcc_op_t op, input logic [7:0] c, input logic [23:0] a, input logic [7:0] d);
    logic [31:0] q;
    int n;
    wb(1'b1, `FCC_REG_ADDR, {8'h00, a}, q);
    wb(1'b1, `FCC_REG_DATA, {24'h0, d}, q);
    wb(1'b1, `FCC_REG_CTRL, {16'h0, c, 4'h0, op, 1'b1}, q);
    // Refused while busy; must not reach the pins
    wb(1'b1, `FCC_REG_DATA, {24'h0, ~d}, q);
    n = 0;
    do begin
      wb(1'b0, `FCC_REG_STAT, 32'h0, q);
      n++;
    end while (q[`FCC_STAT_BUSY] !== 1'b0 && n < 64);
    if (n >= 64) give_up();
    b = q[15:8];
  endtask

  task automatic post(input logic [7:0] v);
    res <= v;
    got <= 1'b1;
    @(posedge clk_i);
    got <= 1'b0;
  endtask

  task automatic chk(input fcc_pkg::fcc_op_t op, input logic [23:0] a, input logic [7:0] e);
    exq.push_back(e);
    run(op, 8'h00, a, 8'h00);
    post(b);
  endtask

  task automatic st(input logic [7:0] e);
    chk(fcc_pkg::FCC_OP_STATUS, 24'h0, e);
  endtask

  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    chk(fcc_pkg::FCC_OP_READ, a, e);
  endtask

  task automatic cmd(input logic [7:0] c);
    run(fcc_pkg::FCC_OP_CMD, c, 24'h0, 8'h00);
  endtask

  task automatic reg_chk(input logic [3:0] a, input logic [7:0] e, input int bit_lo);
    logic [31:0] q;
    exq.push_back(e);
    wb(1'b0, a, 32'h0, q);
    post(bit_lo == 1 ? {7'h00, q[`FCC_STAT_RDYPIN]} : q[7:0]);
  endtask

  // Ready pin as seen through the controller's synchroniser
  task automatic wait_ready();
    logic [31:0] q;
    int n;
    n = 0;
    repeat (4) @(posedge clk_i);
    do begin
      wb(1'b0, `FCC_REG_STAT, 32'h0, q);
      n++;
    end while (q[`FCC_STAT_RDYPIN] !== 1'b1 && n < 2000);
    if (n >= 2000) give_up();
  endtask

  always @(posedge clk_i) begin
    if (got === 1'b1) begin
      if (exq.size() == 0) give_up();
      ex = exq.pop_front();
      `CHK(res, ex)
    end
  end

  initial begin
    static logic [23:0] ida [5] = '{24'h000000, 24'h000001, 24'h010002, 24'h000002, 24'h000003};
    static logic [7:0] ide [5] = '{MAKER, PART, 8'h01, 8'h00, 8'h00};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) chk(fcc_pkg::FCC_OP_IDENT, ida[i], ide[i]);
    rd(24'h000001, PART);
    reg_chk(4'h7, 8'h00, 0);
    st(8'h80);
    rd(24'h000005, 8'h80);
    rd1 = 8'($random(seed));
    rd2 = 8'($random(seed));
    run(fcc_pkg::FCC_OP_PROG, 8'h00, 24'h000003, rd1);
    rd(24'h000003, 8'h00);
    wait_ready();
    rd(24'h000003, 8'h80);
    cmd(8'hFF);
    rd(24'h000003, rd1);
    cmd(8'h10);
    run(fcc_pkg::FCC_OP_WRITE, 8'h00, 24'h000003, rd2);
    wait_ready();
    cmd(8'hFF);
    rd(24'h000003, rd1 & rd2);
    st(8'h80);
    run(fcc_pkg::FCC_OP_ERASE, 8'h00, 24'h000007, 8'h00);
    wait_ready();
    st(8'h80);
    cmd(8'hFF);
    rd(24'h000003, 8'hFF);
    run(fcc_pkg::FCC_OP_PROG, 8'h00, 24'h010000, rd1);
    wait_ready();
    st(8'h92);
    cmd(8'h50);
    st(8'h80);
    run(fcc_pkg::FCC_OP_ERASE, 8'h00, 24'h010000, 8'h00);
    wait_ready();
    st(8'hA2);
    cmd(8'h50);
    vpp_ok <= 1'b0;
    run(fcc_pkg::FCC_OP_PROG, 8'h00, 24'h000004, 8'h00);
    wait_ready();
    st(8'hA8);
    cmd(8'hFF);
    rd(24'h000004, 8'hFF);
    vpp_ok <= 1'b1;
    cmd(8'h50);
    cmd(8'h20);
    cmd(8'hFF);
    st(8'hB0);
    run(fcc_pkg::FCC_OP_ERASE, 8'h00, 24'h000000, 8'h00);
    st(8'h30);
    cmd(8'hFF);
    rd(24'h000003, 8'h30);
    cmd(8'hB0);
    st(8'hF0);
    reg_chk(`FCC_REG_STAT, 8'h01, 1);
    cmd(8'h50);
    st(8'hF0);
    run(fcc_pkg::FCC_OP_PROG, 8'h00, 24'h020001, rd1);
    st(8'h70);
    reg_chk(`FCC_REG_STAT, 8'h00, 1);
    wait_ready();
    cmd(8'hFF);
    rd(24'h020001, rd1);
    cmd(8'hD0);
    st(8'h30);
    wait_ready();
    st(8'hB0);
    cmd(8'h50);
    run(fcc_pkg::FCC_OP_PROG, 8'h00, 24'h000008, rd2);
    cmd(8'hB0);
    st(8'h84);
    cmd(8'h20);
    st(8'h84);
    cmd(8'hD0);
    st(8'h00);
    wait_ready();
    st(8'h80);
    repeat (3) @(posedge clk_i);
    give_verdict();
  end
endmodule // flash_command_state_machine_tb
